// File: inc/dsmr_defines.vh
/*
 * constants of the dual supply monitor reset logic: polarity select codes,
 * timeout option codes and timeout figures with their cycle counts.
 * assumes a 200 MHz core clock.
 */
`ifndef DSMR_DEFINES_VH
`define DSMR_DEFINES_VH

// three-state polarity select, as resolved by the pad
`define DSMR_SEL_GND         2'h0
`define DSMR_SEL_OPEN        2'h1
`define DSMR_SEL_VCC         2'h2

// timeout configuration pin state
`define DSMR_TMO_INTERNAL    2'h0
`define DSMR_TMO_EXTCAP      2'h1
`define DSMR_TMO_COMPARATOR  2'h2

// clock period in ns; counts are kept in ns so products fit in 32 bits
`define DSMR_CLK_NS          5
// internal timeout in ms and its cycle count
`define DSMR_TMO_INT_MS      200
`define DSMR_TMO_INT_CYC    ((`DSMR_TMO_INT_MS * 1000000) / `DSMR_CLK_NS)
// external capacitor timeout default in us (open pin) and cycle count
`define DSMR_TMO_EXT_US      400
`define DSMR_TMO_EXT_CYC    ((`DSMR_TMO_EXT_US * 1000) / `DSMR_CLK_NS)

// reset value of the monitor input synchronisers
`define DSMR_SYNC_RST        3'h0

`endif

// File: logic/dsmr_reset_logic.v
/*
 * decision logic of a dual input supply supervisor: qualifies two monitor
 * comparator results by the latched polarity choice, gates with the supply
 * lockout flag and releases an active-low reset after the selected timeout.
 * assumes comparator, select and timer-pin levels arrive asynchronously and
 * that the lockout flag is high while the supply is below threshold.
 */
// Function
// - decode three-state select into input polarities
// - positive input valid only above trip
// - negative input valid only below trip
// - release only after valid for whole timeout
// - hold reset through power-up, down, brownout
// - latch polarity, init timer after lockout clears
// - start timeout at once if inputs valid
// - assert reset immediately on any invalid input
// - three timeout options: internal, capacitor, none
// - comparator mode: reset follows validity directly
// - invalid input abandons count, restart from zero
`include "dsmr_defines.vh"

module dsmr_reset_logic #(
    parameter [31:0] INT_CYCLES = `DSMR_TMO_INT_CYC,
    parameter [31:0] EXT_CYCLES = `DSMR_TMO_EXT_CYC
) (
    // clock and reset
    input  wire       CLK,
    input  wire       RSTN,
    // comparator results, high when the pin is above its trip point
    input  wire       MONITOR_INPUT_A,
    input  wire       MONITOR_INPUT_B,
    // high while the supply is below the lockout threshold
    input  wire       SUPPLY_LOCKOUT_FLAG,
    // resolved pin states
    input  wire [1:0] POLARITY_SEL,
    input  wire [1:0] TIMEOUT_CONFIG_PIN,
    // supervisor reset
    output reg        RST_N,
    output reg        RST_OE
);

    localparam [2:0] ST_LOCK = 3'h1;
    localparam [2:0] ST_WAIT = 3'h2;
    localparam [2:0] ST_TIME = 3'h4;

    reg  [2:0]  sync_l_q;
    reg  [1:0]  sync_s0_q;
    reg  [1:0]  sync_s1_q;
    reg  [1:0]  sync_s2_q;
    reg  [1:0]  sync_t0_q;
    reg  [1:0]  sync_t1_q;
    reg  [1:0]  sync_t2_q;
    reg         lock_q;
    reg  [1:0]  sel_q;
    reg  [1:0]  tmo_q;
    reg  [1:0]  pol_q;
    reg  [1:0]  mode_q;
    reg  [2:0]  state_q;
    reg  [2:0]  state_d;
    reg  [31:0] cnt_q;
    reg  [31:0] cnt_d;
    reg         rst_n_d;
    reg  [31:0] term;
    reg         pos_a;
    reg         pos_b;
    wire        valid_a;
    wire        valid_b;
    wire        all_ok;
    wire [1:0]  mon_raw;
    wire [1:0]  cmp_w;
    genvar      gi;

    // one synchroniser per monitor channel: bit 1 is input a, bit 0 is b
    assign mon_raw = {MONITOR_INPUT_A, MONITOR_INPUT_B};

    generate
        for (gi = 0; gi < 2; gi = gi + 1)
        begin : g_mon
            reg [2:0] sync_q;
            reg       cmp_q;

            // a level counts once stages 2 and 3 agree, so a one-cycle
            // glitch never reaches the decision logic
            always @(posedge CLK)
            begin
                if (!RSTN)
                begin
                    sync_q <= `DSMR_SYNC_RST;
                    cmp_q  <= 1'b0;
                end
                else
                begin
                    sync_q <= {sync_q[1:0], mon_raw[gi]};
                    if (sync_q[1] == sync_q[2])
                        cmp_q <= sync_q[2];
                end
            end

            assign cmp_w[gi] = cmp_q;
        end
    endgenerate

    // three-stage synchronisers; a level counts once stages 2 and 3 agree
    always @(posedge CLK)
    begin
        if (!RSTN)
        begin
            // stages start at the registered defaults: no false change
            sync_l_q  <= 3'h7;
            sync_s0_q <= `DSMR_SEL_VCC;
            sync_s1_q <= `DSMR_SEL_VCC;
            sync_s2_q <= `DSMR_SEL_VCC;
            sync_t0_q <= `DSMR_TMO_INTERNAL;
            sync_t1_q <= `DSMR_TMO_INTERNAL;
            sync_t2_q <= `DSMR_TMO_INTERNAL;
            lock_q    <= 1'b1;
            sel_q     <= `DSMR_SEL_VCC;
            tmo_q     <= `DSMR_TMO_INTERNAL;
        end
        else
        begin
            sync_l_q  <= {sync_l_q[1:0], SUPPLY_LOCKOUT_FLAG};
            sync_s0_q <= POLARITY_SEL;
            sync_s1_q <= sync_s0_q;
            sync_s2_q <= sync_s1_q;
            sync_t0_q <= TIMEOUT_CONFIG_PIN;
            sync_t1_q <= sync_t0_q;
            sync_t2_q <= sync_t1_q;
            if (sync_l_q[1] == sync_l_q[2])
                lock_q <= sync_l_q[2];
            if (sync_s1_q == sync_s2_q)
                sel_q <= sync_s2_q;
            if (sync_t1_q == sync_t2_q)
                tmo_q <= sync_t2_q;
        end
    end

    // polarity decode: 1 = positive
    always @*
    begin
        case (sel_q)
            `DSMR_SEL_VCC:  {pos_a, pos_b} = 2'h3;
            `DSMR_SEL_OPEN: {pos_a, pos_b} = 2'h2;
            `DSMR_SEL_GND:  {pos_a, pos_b} = 2'h0;
            default:        {pos_a, pos_b} = 2'h3;
        endcase
    end

    assign valid_a = pol_q[1] ? cmp_w[1] : !cmp_w[1];
    assign valid_b = pol_q[0] ? cmp_w[0] : !cmp_w[0];
    assign all_ok  = valid_a && valid_b && !lock_q;

    always @*
    begin
        case (mode_q)
            `DSMR_TMO_EXTCAP: term = EXT_CYCLES;
            default:          term = INT_CYCLES;
        endcase
    end

    always @*
    begin
        state_d = state_q;
        cnt_d   = cnt_q;
        rst_n_d = 1'b0;
        case (state_q)
            ST_LOCK:
            begin
                cnt_d = 32'h0;
                if (!lock_q)
                    state_d = ST_WAIT;
            end
            ST_WAIT:
            begin
                cnt_d = 32'h0;
                if (lock_q)
                    state_d = ST_LOCK;
                else if (mode_q == `DSMR_TMO_COMPARATOR)
                    rst_n_d = all_ok;
                else if (all_ok)
                    state_d = ST_TIME;
            end
            // the count holds at term-1, so the release stands while valid
            ST_TIME:
            begin
                if (!all_ok)
                begin
                    cnt_d   = 32'h0;
                    state_d = lock_q ? ST_LOCK : ST_WAIT;
                end
                else if (cnt_q >= term - 32'h1)
                    rst_n_d = 1'b1;
                else
                    cnt_d = cnt_q + 32'h1;
            end
            default:
                state_d = ST_LOCK;
        endcase
    end

    always @(posedge CLK)
    begin
        if (!RSTN)
        begin
            state_q <= ST_LOCK;
            cnt_q   <= 32'h0;
            pol_q   <= 2'h3;
            mode_q  <= `DSMR_TMO_INTERNAL;
            RST_N   <= 1'b0;
            RST_OE  <= 1'b1;
        end
        else
        begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            // choices freeze when the supply clears lockout; a later pin
            // change waits for the next lockout to take effect
            if (state_q == ST_LOCK)
            begin
                pol_q  <= {pos_a, pos_b};
                mode_q <= tmo_q;
            end
            RST_N  <= rst_n_d;
            // open drain: drive only the low level
            RST_OE <= !rst_n_d;
        end
    end

endmodule // dsmr_reset_logic

// File: dv/dsmr_asserts.sv
/* port checker of the reset logic; assumes counts equal the dut's */
`include "dsmr_defines.vh"
module dsmr_asserts #(
    parameter [31:0] INT_CYCLES = 32'h14,
    parameter [31:0] EXT_CYCLES = 32'h1E
) (
    input wire       CLK, RSTN, MONITOR_INPUT_A, MONITOR_INPUT_B,
    input wire       SUPPLY_LOCKOUT_FLAG, RST_N, RST_OE,
    input wire [1:0] POLARITY_SEL, TIMEOUT_CONFIG_PIN
);
    timeunit 1ns;
    timeprecision 1ps;
    // raw validity: only sound while pins stay still outside lockout
    wire        ok = !SUPPLY_LOCKOUT_FLAG
        && MONITOR_INPUT_A == (POLARITY_SEL != 2'h0)
        && MONITOR_INPUT_B == POLARITY_SEL[1];
    wire [31:0] term = TIMEOUT_CONFIG_PIN == `DSMR_TMO_EXTCAP ? EXT_CYCLES
        : TIMEOUT_CONFIG_PIN == `DSMR_TMO_COMPARATOR ? 32'h0 : INT_CYCLES;
    reg  [31:0] cnt_q;
    wire [31:0] cnt_d = ok ? cnt_q + 32'h1 : 32'h0;
    always @(posedge CLK)
    begin
        cnt_q <= RSTN ? cnt_d : 32'h0;
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (!RSTN);
    a_invalid_low: assert property (!ok [*8] |-> !RST_N)
        else $error("reset released while invalid");
    a_lock_drop: assert property ($rose(SUPPLY_LOCKOUT_FLAG)
        |-> ##[1:8] !RST_N) else $error("lockout did not assert reset");
    a_init_wait: assert property ($fell(SUPPLY_LOCKOUT_FLAG)
        |-> !RST_N [*3]) else $error("reset released during init");
    a_release_late: assert property ($rose(RST_N) |-> cnt_q >= term)
        else $error("reset released before timeout");
    a_release_due: assert property (cnt_q >= term + 32'hC |-> RST_N)
        else $error("reset not released after timeout");
    a_comp_follow: assert property ((ok && TIMEOUT_CONFIG_PIN ==
        `DSMR_TMO_COMPARATOR) [*8] |-> RST_N) else $error("no follow");
    a_low_held: assert property (!RST_N && !ok |=> !RST_N)
        else $error("reset rose while invalid");
    a_oe_drive: assert property (RST_OE != RST_N)
        else $error("enable does not match reset level");
    cover property ($rose(RST_N) && TIMEOUT_CONFIG_PIN == 2'h1);
    cover property ($rose(RST_N) && TIMEOUT_CONFIG_PIN == 2'h2);
    cover property ($fell(RST_N) && !SUPPLY_LOCKOUT_FLAG);
endmodule // dsmr_asserts
bind dsmr_reset_logic dsmr_asserts #(.INT_CYCLES(INT_CYCLES),
    .EXT_CYCLES(EXT_CYCLES)) chk (.CLK(CLK), .RSTN(RSTN),
    .MONITOR_INPUT_A(MONITOR_INPUT_A), .MONITOR_INPUT_B(MONITOR_INPUT_B),
    .SUPPLY_LOCKOUT_FLAG(SUPPLY_LOCKOUT_FLAG), .RST_N(RST_N),
    .RST_OE(RST_OE), .POLARITY_SEL(POLARITY_SEL),
    .TIMEOUT_CONFIG_PIN(TIMEOUT_CONFIG_PIN));

// File: dv/dsmr_sys_model.sv
/* system side of the reset line; assumes an external pull-up */
module dsmr_sys_model (
    input  wire  rst_oe,
    output logic sys_rst_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // open drain: pulled high whenever the supervisor lets go
    assign sys_rst_n = !rst_oe;
endmodule // dsmr_sys_model

// File: dv/test_dual_supply_monitor_reset_logic.sv
/* bench of the reset logic; assumes short timeout parameters */
module test_dual_supply_monitor_reset_logic;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk = 0, rstn = 0, a = 0, b = 0, lock = 1;
    logic [1:0] pol = 2'h0, tmo = 2'h0;
    wire        rst_n, oe, sys_n;
    int         mismatches = 0, compares = 0;
    always #2.5 clk = ~clk;
    dsmr_reset_logic #(.INT_CYCLES(32'h14), .EXT_CYCLES(32'h1E)) dut (
        .CLK(clk), .RSTN(rstn), .MONITOR_INPUT_A(a), .MONITOR_INPUT_B(b),
        .SUPPLY_LOCKOUT_FLAG(lock), .POLARITY_SEL(pol),
        .TIMEOUT_CONFIG_PIN(tmo), .RST_N(rst_n), .RST_OE(oe));
    dsmr_sys_model sys (.rst_oe(oe), .sys_rst_n(sys_n));
    task wt(input int n);
        repeat (n) @(negedge clk);
    endtask
    task chk(input logic e);
        compares++;
        if (sys_n !== e)
        begin
            mismatches++;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, sys_n);
        end
        compares++;
        if (rst_n !== e)
        begin
            mismatches++;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, rst_n);
        end
    endtask
    task conclude;
        $display("mismatches=%0d compares=%0d", mismatches, compares);
        if (mismatches == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // power up with given pins; va, vb are the valid levels
    task t_mode(input [1:0] p, m, input logic va, vb, input int n);
        lock = 1; pol = p; tmo = m; a = va; b = vb;
        wt(6);
        chk(0);
        lock = 0;
        wt(n + 1);
        chk(0);
        wt(12);
        chk(1);
        a = !va;
        wt(8);
        chk(0);
        a = va;
        wt(n + 14);
        b = !vb;
        wt(8);
        chk(0);
        b = vb;
        wt(n + 14);
        chk(1);
    endtask
    // invalid in mid-count must start the timeout afresh
    task t_restart;
        lock = 1; pol = 2'h2; tmo = 2'h0; a = 1; b = 1;
        wt(6);
        lock = 0;
        wt(12);
        a = 0;
        wt(10);
        a = 1;
        wt(22);
        chk(0);
        wt(12);
        chk(1);
        lock = 1;
        wt(8);
        chk(0);
    endtask
    // reset in mid-run drops the output and restarts the timeout
    task t_reset;
        lock = 0;
        wt(40);
        chk(1);
        rstn = 0;
        wt(3);
        chk(0);
        rstn = 1;
        wt(21);
        chk(0);
        wt(12);
        chk(1);
    endtask
    initial
    begin
        wt(12);
        rstn = 1;
        t_mode(2'h2, 2'h0, 1, 1, 20);
        t_mode(2'h1, 2'h1, 1, 0, 30);
        t_mode(2'h0, 2'h2, 0, 0, 0);
        t_mode(2'h3, 2'h3, 1, 1, 20);
        t_restart();
        t_reset();
        conclude();
    end
    initial
    begin
        #10us;
        mismatches++;
        conclude();
    end
endmodule // test_dual_supply_monitor_reset_logic
